// ==== hw/sinc_pkg.sv ====
// constants for the sinc decimator, clock and power control block
package sinc_pkg;
  // register byte addresses
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] OFFSET_ADDR = 8'h04;
  localparam logic [7:0] STATUS_ADDR = 8'h08;
  localparam logic [7:0] RESULT_ADDR = 8'h0C;
  localparam logic [7:0] DECIM_ADDR = 8'h10;
  // control field positions
  localparam int STANDBY_BIT = 0;
  localparam int SHUT_BIT = 1;
  localparam int HALV_BIT = 2;
  localparam int PASS_BIT = 3;
  localparam int QUICK_BIT = 4;
  localparam int HOLD_BIT = 5;
  localparam int RATE_BIT = 6;
  localparam int MF_LO = 7;
  localparam int FS_LO = 9;
  localparam int UNI_BIT = 11;
  localparam int SWRST_BIT = 12;
  localparam int CTRL_W = 12;
  localparam logic [CTRL_W-1:0] CTRL_RST = 12'h040;
  localparam logic [3:0] OFFSET_RST = 4'h0;
  // filter datapath
  localparam int ACC_W = 27;
  localparam int N_W = 9;
  localparam int SET_W = 3;
  localparam logic [SET_W-1:0] SINC1_SETTLE = 3'h1;
  localparam logic [SET_W-1:0] SINC3_SYNC_SETTLE = 3'h3;
  localparam logic [SET_W-1:0] SINC3_FREE_SETTLE = 3'h4;
  // modulator divider at the lowest modulator frequency select
  localparam logic [7:0] MOD_DIV_BASE = 8'h80;
  // cutoff over first notch, in thousandths
  localparam int CUTOFF_PER_MILLE = 262;
  // offset steps in tenths of a percent of range
  localparam logic [10:0] UNI_STEP [8] = '{11'h000, 11'h0A7, 11'h14D, 11'h1F4,
                                          11'h29B, 11'h341, 11'h3E8, 11'h48F};
  localparam logic [10:0] BI_STEP [8] = '{11'h000, 11'h053, 11'h0A7, 11'h0FA,
                                         11'h14D, 11'h1A1, 11'h1F4, 11'h247};
  // decimation factor per master rate select and rate select
  localparam logic [N_W-1:0] DECIM_TAB [8] = '{9'h0A0, 9'h085, 9'h01B, 9'h00D,
                                              9'h180, 9'h140, 9'h040, 9'h020};
endpackage : sinc_pkg

// ==== hw/sinc_core.sv ====
// cascaded integrator comb core for the first and third order sinc
`timescale 1ns/1ps
`default_nettype none
module sinc_core
  import sinc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic clear,
  input wire logic sample_en,
  input wire logic dump,
  input wire logic order3,
  input wire logic bit_in,
  // result
  output logic [ACC_W-1:0] word_ff,
  output logic word_stb_ff
);
  logic [ACC_W-1:0] integ_ff [3];
  logic [ACC_W-1:0] comb_in [4];
  logic [ACC_W-1:0] comb_dly_ff [3];

  // a stream bit counts as one or zero; modulo wrap is harmless in the combs
  assign comb_in[0] = order3 ? integ_ff[2] : integ_ff[0];
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_stage
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          integ_ff[g] <= '0;
          comb_dly_ff[g] <= '0;
        end else if (clear) begin
          integ_ff[g] <= '0;
          comb_dly_ff[g] <= '0;
        end else begin
          if (sample_en) begin
            if (g == 0) begin
              integ_ff[g] <= integ_ff[g] + {{(ACC_W-1){1'b0}}, bit_in};
            end else begin
              integ_ff[g] <= integ_ff[g] + integ_ff[g-1];
            end
          end
          if (dump) begin
            comb_dly_ff[g] <= comb_in[g];
          end
        end
      end
      assign comb_in[g+1] = comb_in[g] - comb_dly_ff[g];
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      word_ff <= '0;
      word_stb_ff <= 1'b0;
    end else begin
      word_stb_ff <= dump & ~clear;
      if (dump & ~clear) begin
        word_ff <= order3 ? comb_in[3] : comb_in[1];
      end
    end
  end
endmodule : sinc_core
`default_nettype wire

// ==== hw/sinc_decimator_ctrl.sv ====
// apb-controlled sinc decimator with clock prescaler and power control
//
// The APB register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module sinc_decimator_ctrl
  import sinc_pkg::*;
(
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // oscillator and modulator side
  input wire logic oscillator_input,
  input wire logic mod_bit,
  output logic oscillator_enable,
  output logic analog_power_en,
  // offset dac
  output logic [2:0] offset_dac_mag,
  output logic offset_dac_neg,
  output logic offset_dac_connect,
  output logic [10:0] offset_shift_tenths,
  // serial side
  input wire logic serial_shift_bit,
  output logic serial_data_out,
  output logic result_valid
);
  ////////////////////////////////////////////////////////////////////////////
  logic [CTRL_W-1:0] ctrl_ff;
  logic [3:0] offset_ff;
  logic [ACC_W-1:0] result_ff;
  logic data_ready_ff;
  logic [SET_W-1:0] settle_cnt_ff;
  logic [SET_W-1:0] settle_tgt_ff;
  logic soft_rst_ff;
  logic wr_en;
  logic rd_en;
  logic ctrl_wr;
  logic [CTRL_W-1:0] nxt_ctrl;
  logic rate_change;
  logic result_rd;
  logic [2:0] osc_sync_ff;
  logic [1:0] mod_sync_ff;
  logic osc_rise;
  logic half_ff;
  logic int_tick;
  logic [7:0] mod_div_ff;
  logic [7:0] mod_div_end;
  logic mod_tick;
  logic [N_W-1:0] decim_cnt_ff;
  logic [N_W-1:0] decim_n;
  logic run;
  logic filt_clear;
  logic dump;
  logic [ACC_W-1:0] word;
  logic word_stb;
  logic standby_exit;
  logic settled;

  wire standby_request = ctrl_ff[STANDBY_BIT];
  wire full_shutdown = ctrl_ff[SHUT_BIT];
  wire input_halver_enable = ctrl_ff[HALV_BIT];
  wire modulator_passthrough = ctrl_ff[PASS_BIT];
  wire quick_settle = ctrl_ff[QUICK_BIT];
  wire filter_sync_hold = ctrl_ff[HOLD_BIT];
  wire master_rate_sel = ctrl_ff[RATE_BIT];
  wire modulator_freq_sel_lo = ctrl_ff[MF_LO];
  wire modulator_freq_sel_hi = ctrl_ff[MF_LO+1];
  wire rate_select_lo = ctrl_ff[FS_LO];
  wire rate_select_hi = ctrl_ff[FS_LO+1];
  wire unipolar = ctrl_ff[UNI_BIT];

  function automatic logic [10:0] offset_step(input logic uni, input logic [2:0] mag);
    offset_step = uni ? UNI_STEP[mag] : BI_STEP[mag];
  endfunction : offset_step

  ////////////////////////////////////////////////////////////////////////////
  // apb decode; zero wait states, so every access ends in its first access cycle
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign ctrl_wr = wr_en && (paddr == CTRL_ADDR);
  assign result_rd = rd_en && (paddr == RESULT_ADDR);
  assign nxt_ctrl = pwdata[CTRL_W-1:0];
  // a new rate setting restarts the filter from a clean state
  assign rate_change = ctrl_wr && ((nxt_ctrl[FS_LO+1:FS_LO] != ctrl_ff[FS_LO+1:FS_LO]) ||
                                   (nxt_ctrl[MF_LO+1:MF_LO] != ctrl_ff[MF_LO+1:MF_LO]) ||
                                   (nxt_ctrl[RATE_BIT] != ctrl_ff[RATE_BIT]) ||
                                   (nxt_ctrl[HALV_BIT] != ctrl_ff[HALV_BIT]));

  always_comb begin
    pslverr = 1'b0;
    prdata = 32'h0000_0000;
    if (paddr == CTRL_ADDR) begin
      prdata[CTRL_W-1:0] = ctrl_ff;
    end else if (paddr == OFFSET_ADDR) begin
      prdata[3:0] = offset_ff;
    end else if (paddr == STATUS_ADDR) begin
      prdata[5:0] = {settle_cnt_ff, settled, data_ready_ff, ~analog_power_en};
    end else if (paddr == RESULT_ADDR) begin
      prdata[ACC_W-1:0] = result_ff;
    end else if (paddr == DECIM_ADDR) begin
      prdata[N_W-1:0] = decim_n;
    end else begin
      pslverr = psel & penable;
    end
  end

  // software reset returns the registers, filter and result to their reset state one cycle later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_rst_ff <= 1'b0;
    end else begin
      soft_rst_ff <= ctrl_wr & pwdata[SWRST_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= CTRL_RST;
      offset_ff <= OFFSET_RST;
    end else if (soft_rst_ff) begin
      ctrl_ff <= CTRL_RST;
      offset_ff <= OFFSET_RST;
    end else begin
      if (ctrl_wr) begin
        ctrl_ff <= nxt_ctrl;
      end
      if (wr_en && (paddr == OFFSET_ADDR)) begin
        offset_ff <= pwdata[3:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // offset dac code
  assign offset_dac_mag = offset_ff[2:0];
  assign offset_dac_neg = offset_ff[3];
  // a signed zero is still zero, so only the magnitude decides
  assign offset_dac_connect = (offset_ff[2:0] != 3'h0);
  // tables step 16.7 or 8.3 percent, rounded so full scale hits 116.7 or 58.3
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      offset_shift_tenths <= 11'h000;
    end else begin
      offset_shift_tenths <= offset_step(unipolar, offset_ff[2:0]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oscillator_enable <= 1'b1;
      analog_power_en <= 1'b1;
    end else begin
      oscillator_enable <= ~full_shutdown;
      analog_power_en <= ~(standby_request | full_shutdown);
    end
  end
  // leaving standby is not synchronized to the input, so third order settle takes longer
  assign standby_exit = analog_power_en & ~oscillator_enable ? 1'b0 :
                        (~analog_power_en & ~(standby_request | full_shutdown));

  ////////////////////////////////////////////////////////////////////////////
  // oscillator and modulator stream crossing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_sync_ff <= 3'h0;
      mod_sync_ff <= 2'h0;
    end else begin
      osc_sync_ff <= {osc_sync_ff[1:0], oscillator_input};
      mod_sync_ff <= {mod_sync_ff[0], mod_bit};
    end
  end
  assign osc_rise = osc_sync_ff[1] & ~osc_sync_ff[2];

  // halver keeps 50 percent duty by taking every second rising edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_ff <= 1'b0;
    end else if (!input_halver_enable) begin
      half_ff <= 1'b0;
    end else if (osc_rise) begin
      half_ff <= ~half_ff;
    end
  end
  assign int_tick = osc_rise & (~input_halver_enable | half_ff);

  // standby and shutdown stop the filter; hold halts measurement
  assign run = analog_power_en & ~filter_sync_hold;
  assign filt_clear = soft_rst_ff | rate_change | filter_sync_hold;

  assign mod_div_end = (MOD_DIV_BASE >> {modulator_freq_sel_hi, modulator_freq_sel_lo}) - 8'h01;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mod_div_ff <= 8'h00;
    end else if (filt_clear || !run) begin
      mod_div_ff <= 8'h00;
    end else if (int_tick) begin
      mod_div_ff <= (mod_div_ff >= mod_div_end) ? 8'h00 : mod_div_ff + 8'h01;
    end
  end
  assign mod_tick = run & ~filt_clear & int_tick & (mod_div_ff >= mod_div_end);

  ////////////////////////////////////////////////////////////////////////////
  // decimation counter: one word per n modulator bits
  assign decim_n = DECIM_TAB[{master_rate_sel, rate_select_hi, rate_select_lo}];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      decim_cnt_ff <= '0;
    end else if (filt_clear) begin
      decim_cnt_ff <= '0;
    end else if (mod_tick) begin
      decim_cnt_ff <= (decim_cnt_ff >= decim_n - 9'h001) ? '0 : decim_cnt_ff + 9'h001;
    end
  end
  // word period equals the first notch, so notches fall at its multiples
  assign dump = mod_tick & (decim_cnt_ff >= decim_n - 9'h001);

  sinc_core u_core (
    .clk(pclk),
    .rst_n(presetn),
    .clear(filt_clear),
    .sample_en(mod_tick),
    .dump(dump),
    .order3(~quick_settle),
    .bit_in(mod_sync_ff[1]),
    .word_ff(word),
    .word_stb_ff(word_stb)
  );

  ////////////////////////////////////////////////////////////////////////////
  // settling: count words since the last disturbance
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_cnt_ff <= '0;
      settle_tgt_ff <= SINC3_SYNC_SETTLE;
    end else if (filt_clear) begin
      settle_cnt_ff <= '0;
      settle_tgt_ff <= (ctrl_wr ? nxt_ctrl[QUICK_BIT] : quick_settle) ? SINC1_SETTLE : SINC3_SYNC_SETTLE;
    end else if (ctrl_wr && (nxt_ctrl[QUICK_BIT] != quick_settle)) begin
      settle_cnt_ff <= '0;
      settle_tgt_ff <= nxt_ctrl[QUICK_BIT] ? SINC1_SETTLE : SINC3_SYNC_SETTLE;
    end else if (standby_exit) begin
      settle_cnt_ff <= '0;
      settle_tgt_ff <= quick_settle ? SINC1_SETTLE : SINC3_FREE_SETTLE;
    end else if (word_stb && (settle_cnt_ff < SINC3_FREE_SETTLE)) begin
      settle_cnt_ff <= settle_cnt_ff + 3'h1;
    end
  end
  assign settled = (settle_cnt_ff >= settle_tgt_ff);

  // result register; holding sync stops new words, so the host reads a stable value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_ff <= '0;
    end else if (soft_rst_ff) begin
      result_ff <= '0;
    end else if (word_stb) begin
      result_ff <= word;
    end
  end

  // a new settled word beats a read in the same cycle; disturbances drop it at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_ready_ff <= 1'b0;
    end else if (!settled || filt_clear) begin
      data_ready_ff <= 1'b0;
    end else if (word_stb) begin
      data_ready_ff <= 1'b1;
    end else if (result_rd) begin
      data_ready_ff <= 1'b0;
    end
  end
  assign result_valid = data_ready_ff & settled;

  ////////////////////////////////////////////////////////////////////////////
  // serial output: raw stream when the filter is bypassed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_data_out <= 1'b0;
    end else begin
      serial_data_out <= modulator_passthrough ? mod_sync_ff[1] : serial_shift_bit;
    end
  end
endmodule : sinc_decimator_ctrl
`default_nettype wire

// ==== sim/sinc_far_side_model.sv ====
// far side model: crystal oscillator, modulator stream and host data line
`timescale 1ns/1ps
`default_nettype none
module sinc_far_side_model (
  // bench control
  input wire logic pclk,
  input wire logic mod_level,
  // device pins
  input wire logic oscillator_enable,
  output logic oscillator_input,
  output logic mod_bit,
  output logic serial_shift_bit
);
  ////////////////////////////////////////////////////////////////
  // 160 ns crystal, phase offset from pclk; stands low while shut down
  initial begin
    oscillator_input = 1'b0;
    #7;
    forever begin
      #80;
      oscillator_input = (oscillator_enable !== 1'b0) ? !oscillator_input : 1'b0;
    end
  end
  // host data keeps moving so a stale copy never passes for a match
  initial begin
    serial_shift_bit = 1'b0;
  end
  always @(posedge pclk) begin
    serial_shift_bit <= !serial_shift_bit;
  end
  assign mod_bit = mod_level;
endmodule : sinc_far_side_model
`default_nettype wire

// ==== sim/sinc_decimator_ctrl_chk.sv ====
// concurrent checks on the sinc decimator control block ports
`timescale 1ns/1ps
`default_nettype none
module sinc_decimator_ctrl_chk
  import sinc_pkg::*;
(
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  // watched outputs
  input wire logic oscillator_enable,
  input wire logic analog_power_en,
  input wire logic [2:0] offset_dac_mag,
  input wire logic offset_dac_connect,
  input wire logic [10:0] offset_shift_tenths,
  input wire logic serial_shift_bit,
  input wire logic serial_data_out,
  input wire logic result_valid
);
  logic cw;
  logic [1:0] quiet_ff;
  logic uni_ff, quick_ff, pass_ff;
  assign cw = psel && penable && pwrite && paddr == CTRL_ADDR;
  ////////////////////////////////////////////////////////////////
  // registered outputs trail a write, so judge them only once quiet
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quiet_ff <= 2'h0;
    end else if (psel && penable && pwrite) begin
      quiet_ff <= 2'h0;
    end else if (quiet_ff != 2'h3) begin
      quiet_ff <= quiet_ff + 2'h1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {uni_ff, quick_ff, pass_ff} <= 3'h0;
    end else if (cw) begin
      {uni_ff, quick_ff, pass_ff} <= pwdata[SWRST_BIT] ? 3'h0 :
        {pwdata[UNI_BIT], pwdata[QUICK_BIT], pwdata[PASS_BIT]};
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_UNMAPPED: assert property (psel && penable && paddr > DECIM_ADDR |-> pslverr)
    else $error("no error on unmapped address");
  AST_CONNECT: assert property (offset_dac_connect == (offset_dac_mag != 3'h0))
    else $error("offset dac connect wrong");
  AST_SHIFT: assert property (quiet_ff == 2'h3 |-> offset_shift_tenths ==
    (uni_ff ? UNI_STEP[offset_dac_mag] : BI_STEP[offset_dac_mag])) else $error("offset shift wrong");
  AST_STANDBY: assert property (cw && pwdata[STANDBY_BIT] && !pwdata[SHUT_BIT] && !pwdata[SWRST_BIT]
    |-> ##[1:2] !analog_power_en && oscillator_enable) else $error("standby power wrong");
  AST_SHUT: assert property (cw && pwdata[SHUT_BIT] && !pwdata[SWRST_BIT]
    |-> ##[1:2] !oscillator_enable && !analog_power_en) else $error("shutdown power wrong");
  AST_RESET: assert property ($rose(presetn) |-> oscillator_enable && analog_power_en && !result_valid)
    else $error("reset state wrong");
  AST_SER: assert property (quiet_ff == 2'h3 && !pass_ff |-> serial_data_out == $past(serial_shift_bit))
    else $error("serial out not from shift path");
  AST_QUICK: assert property (cw && quick_ff && !pwdata[QUICK_BIT] |-> ##2 !result_valid [*8])
    else $error("valid did not drop");
endmodule : sinc_decimator_ctrl_chk
bind sinc_decimator_ctrl sinc_decimator_ctrl_chk chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pslverr, .oscillator_enable, .analog_power_en, .offset_dac_mag, .offset_dac_connect,
  .offset_shift_tenths, .serial_shift_bit, .serial_data_out, .result_valid);
`default_nettype wire

// ==== sim/sinc_decimator_ctrl_tb_top.sv ====
// self-checking testbench for the sinc decimator control block
`timescale 1ns/1ps
`default_nettype none
module sinc_decimator_ctrl_tb_top;
  import sinc_pkg::*;
  // pclk per word at n 13, modulator divider 16, 8 pclk per oscillator period
  localparam int WORD = 1664;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic mod_level = 1'b1;
  logic [31:0] prdata, q;
  logic [2:0] offset_dac_mag;
  logic [10:0] offset_shift_tenths;
  logic pready, pslverr, err, oscillator_input, mod_bit, oscillator_enable, analog_power_en;
  logic offset_dac_neg, offset_dac_connect, serial_shift_bit, serial_data_out, result_valid;
  int fails = 0;
  int checks_done = 0;
  int n;
  initial begin
    forever #10 pclk = !pclk;
  end
  sinc_decimator_ctrl uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .oscillator_input, .mod_bit, .oscillator_enable, .analog_power_en, .offset_dac_mag,
    .offset_dac_neg, .offset_dac_connect, .offset_shift_tenths, .serial_shift_bit, .serial_data_out,
    .result_valid);
  sinc_far_side_model far (.pclk, .mod_level, .oscillator_enable, .oscillator_input, .mod_bit,
    .serial_shift_bit);
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // one extra edge at the end so the next setup never lands on the release
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rd
  // wait for a settled word, bounded, then read it like the host would
  task automatic step(input int lim, input logic [31:0] e);
    n = 0;
    while (result_valid !== 1'b1 && n < lim) begin
      @(posedge pclk);
      n++;
    end
    chk(n < lim, 1);
    rd(RESULT_ADDR, e);
  endtask : step
  task automatic summarize;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (80000) @(posedge pclk);
    fails++;
    summarize();
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(CTRL_ADDR, 32'h40);
    rd(OFFSET_ADDR, 32'h0);
    rd(8'h14, 32'h0);
    chk(err, 1);
    for (int i = 0; i < 8; i++) begin
      wr(CTRL_ADDR, (32'(i / 4) << RATE_BIT) | (32'(i % 4) << FS_LO));
      rd(DECIM_ADDR, 32'(DECIM_TAB[i]));
    end
    for (int u = 0; u < 2; u++) begin
      wr(CTRL_ADDR, 32'(u) << UNI_BIT);
      for (int c = 0; c < 16; c++) begin
        wr(OFFSET_ADDR, 32'(c));
        repeat (3) @(posedge pclk);
        chk({offset_dac_neg, offset_dac_mag}, 32'(c));
        chk(offset_dac_connect, 32'(c % 8 != 0));
        chk(offset_shift_tenths, 32'(u ? (1000 * (c % 8) + 3) / 6 : (1000 * (c % 8) + 6) / 12));
      end
    end
    wr(CTRL_ADDR, 32'h1);
    repeat (3) @(posedge pclk);
    chk({oscillator_enable, analog_power_en}, 32'h2);
    wr(CTRL_ADDR, 32'h2);
    repeat (3) @(posedge pclk);
    chk({oscillator_enable, analog_power_en}, 32'h0);
    wr(CTRL_ADDR, 32'h0);
    repeat (500) @(posedge pclk);
    wr(CTRL_ADDR, 32'h1000);
    rd(CTRL_ADDR, 32'h40);
    wr(CTRL_ADDR, 32'h8);
    mod_level <= 1'b0;
    repeat (8) @(posedge pclk);
    chk(serial_data_out, 0);
    mod_level <= 1'b1;
    repeat (8) @(posedge pclk);
    chk(serial_data_out, 1);
    wr(CTRL_ADDR, 32'h790);
    step(2 * WORD + 200, 32'd13);
    step(WORD + 40, 32'd13);
    chk(n > WORD - 40, 1);
    wr(CTRL_ADDR, 32'h780);
    step(4 * WORD, 32'd2197);
    chk(n > 2 * WORD, 1);
    wr(CTRL_ADDR, 32'h781);
    repeat (20) @(posedge pclk);
    wr(CTRL_ADDR, 32'h780);
    step(6 * WORD, 32'd2197);
    chk(n > 3 * WORD, 1);
    wr(CTRL_ADDR, 32'h794);
    step(5 * WORD, 32'd13);
    step(2 * WORD + 40, 32'd13);
    chk(n > 2 * WORD - 40, 1);
    wr(CTRL_ADDR, 32'h7B4);
    repeat (3 * WORD) @(posedge pclk);
    chk(result_valid, 0);
    wr(CTRL_ADDR, 32'h794);
    step(5 * WORD, 32'd13);
    summarize();
  end
endmodule : sinc_decimator_ctrl_tb_top
`default_nettype wire
